// File: vfp_pkg.sv
package vfp_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int LVL_W = 16;
   localparam int MULT_W = 4;
   localparam int PROD_W = LVL_W + MULT_W;
   localparam int THR_W = PROD_W + 1;
   localparam int IRQ_W = 3;

   // ------------------------------------------------------------
   // Register offsets (byte addresses, one word each)
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_SELECT = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_MULT = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_AVG = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_STD = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_THRESH = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_STATE = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_CONT_SEC = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_CUM_SEC = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h24;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int ST_PRED_LSB = 0;
   localparam int ST_PRED_W = 4;
   localparam int ST_WARN_BIT = 4;
   localparam int ST_LEARNED_BIT = 5;
   localparam int ST_CONT_MET_BIT = 6;
   localparam int IRQ_WARN_SET = 0;
   localparam int IRQ_WARN_CLR = 1;
   localparam int IRQ_LEARNED = 2;

   // Prediction status codes
   localparam logic [ST_PRED_W-1:0] PST_DISABLED = 4'h0;
   localparam logic [ST_PRED_W-1:0] PST_PREPARE = 4'h1;
   localparam logic [ST_PRED_W-1:0] PST_EXECUTE = 4'h2;
   localparam logic [ST_PRED_W-1:0] PST_WARNING = 4'h3;

   // ------------------------------------------------------------
   // Modes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      VFP_OFF,
      VFP_AUTO,
      VFP_MANUAL,
      VFP_RESET
   } vfp_mode_t;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam vfp_mode_t SELECT_RST = VFP_OFF;
   localparam logic [MULT_W-1:0] MULT_RST = 4'h0;
   localparam logic [LVL_W-1:0] AVG_RST = 16'h0000;
   localparam logic [LVL_W-1:0] STD_RST = 16'h0000;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
   localparam logic [MULT_W-1:0] MULT_ZERO_SUB = 4'h5;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 200_000_000;
   localparam int TICK_SECONDS = 1;
   localparam int TICK_CYCLES = CLK_HZ * TICK_SECONDS;
   localparam int SEC_PER_HOUR = 3600;
   localparam int LEARN_CONT_HOURS = 3;
   localparam int LEARN_CUM_HOURS = 90;
   localparam int LEARN_CONT_SEC = LEARN_CONT_HOURS * SEC_PER_HOUR;
   localparam int LEARN_CUM_SEC = LEARN_CUM_HOURS * SEC_PER_HOUR;
   localparam logic [1:0] BOOT_WAIT = 2'h2;
   localparam int STATS_SHIFT = 6;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } vfp_bus_req_t;

   typedef struct packed {
      logic [LVL_W-1:0] level;
      logic valid;
      logic running;
      logic pos_vel_mode;
   } vfp_vib_t;

endpackage

// File: vfp_stats.sv
`timescale 1ns/100ps
module vfp_stats #(
   parameter int W = 16,
   parameter int SHIFT = 6
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clear,
   input wire logic sample_valid,
   input wire logic [W-1:0] sample,
   output logic [W-1:0] mean,
   output logic [W-1:0] dev,
   output logic seeded
);
   // Exponential averages keep SHIFT fraction bits so small steps count
   logic [W+SHIFT-1:0] mean_acc_r;
   logic [W+SHIFT-1:0] dev_acc_r;
   logic seeded_r;
   logic [W-1:0] abs_diff;

   assign mean = mean_acc_r[W+SHIFT-1:SHIFT];
   assign dev = dev_acc_r[W+SHIFT-1:SHIFT];
   assign seeded = seeded_r;

   always_comb begin
      if (sample >= mean) begin
         abs_diff = sample - mean;
      end else begin
         abs_diff = mean - sample;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mean_acc_r <= '0;
         dev_acc_r <= '0;
         seeded_r <= 1'b0;
      end else if (clear) begin
         mean_acc_r <= '0;
         dev_acc_r <= '0;
         seeded_r <= 1'b0;
      end else if (sample_valid) begin
         seeded_r <= 1'b1;
         if (!seeded_r) begin
            // First sample seeds the mean to skip a long ramp from zero
            mean_acc_r <= {sample, {SHIFT{1'b0}}};
         end else begin
            mean_acc_r <= mean_acc_r - (mean_acc_r >> SHIFT)
                          + (W+SHIFT)'(sample);
            dev_acc_r <= dev_acc_r - (dev_acc_r >> SHIFT)
                         + (W+SHIFT)'(abs_diff);
         end
      end
   end
endmodule // vfp_stats

// File: vfp_top.sv
`timescale 1ns/100ps
module vfp_top
   import vfp_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = vfp_pkg::TICK_CYCLES,
   parameter int unsigned CONT_SECONDS = vfp_pkg::LEARN_CONT_SEC,
   parameter int unsigned CUM_SECONDS = vfp_pkg::LEARN_CUM_SEC,
   parameter int STATS_SHIFT = vfp_pkg::STATS_SHIFT
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire vfp_pkg::vfp_bus_req_t bus_req,
   output logic [vfp_pkg::DATA_W-1:0] reg_rdata,
   input wire vfp_pkg::vfp_vib_t vib_in,
   input wire logic [1:0] boot_select,
   output logic vib_prediction_warning,
   output logic irq
);
   import vfp_pkg::*;

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   vfp_mode_t vib_warn_select_r;
   logic [MULT_W-1:0] threshold_multiplier_r;
   logic [LVL_W-1:0] vib_average_characteristic_r;
   logic [LVL_W-1:0] vib_standard_deviation_r;
   logic [THR_W-1:0] thresh_r;
   logic [THR_W-1:0] thresh_cur;
   logic warn_r;
   logic warn_nxt;
   logic learned_r;
   logic [1:0] boot_s1_r;
   logic [1:0] boot_s2_r;
   logic [1:0] boot_cnt_r;
   logic boot_done_r;
   logic boot_load;
   logic [31:0] tick_cnt_r;
   logic sec_tick;
   logic [31:0] cont_sec_r;
   logic [31:0] cum_sec_r;
   logic cont_met_r;
   logic learning;
   logic learn_done;
   logic [LVL_W-1:0] stat_mean;
   logic [LVL_W-1:0] stat_dev;
   logic stat_seeded;
   logic [LVL_W-1:0] std_est;
   logic [MULT_W-1:0] mult_eff;
   logic [PROD_W-1:0] product;
   logic [IRQ_W-1:0] irq_stat_r;
   logic [IRQ_W-1:0] irq_mask_r;
   logic [IRQ_W-1:0] irq_events;
   logic irq_r;
   logic [DATA_W-1:0] rdata_r;
   logic [ST_PRED_W-1:0] pred_status;
   logic wr_sel;
   logic wr_mult;
   logic wr_avg;
   logic wr_std;
   logic wr_mask;
   logic rd_irq;

   assign wr_sel = bus_req.wr && (bus_req.addr == OFS_SELECT);
   assign wr_mult = bus_req.wr && (bus_req.addr == OFS_MULT);
   assign wr_avg = bus_req.wr && (bus_req.addr == OFS_AVG);
   assign wr_std = bus_req.wr && (bus_req.addr == OFS_STD);
   assign wr_mask = bus_req.wr && (bus_req.addr == OFS_IRQ_MASK);
   assign rd_irq = bus_req.rd && (bus_req.addr == OFS_IRQ_STAT);

   assign reg_rdata = rdata_r;
   assign vib_prediction_warning = warn_r;
   assign irq = irq_r;

   // ------------------------------------------------------------
   // Power-up selection load
   // ------------------------------------------------------------
   // The stored selection comes from non-volatile storage outside
   // this clock, so it is synchronised and caught once after release.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         boot_s1_r <= 2'h0;
         boot_s2_r <= 2'h0;
      end else begin
         boot_s1_r <= boot_select;
         boot_s2_r <= boot_s1_r;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         boot_cnt_r <= 2'h0;
         boot_done_r <= 1'b0;
      end else if (!boot_done_r) begin
         if (boot_cnt_r == BOOT_WAIT) begin
            boot_done_r <= 1'b1;
         end else begin
            boot_cnt_r <= boot_cnt_r + 2'h1;
         end
      end
   end

   assign boot_load = !boot_done_r && (boot_cnt_r == BOOT_WAIT);

   // ------------------------------------------------------------
   // Selection and threshold settings
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         vib_warn_select_r <= SELECT_RST;
      end else if (boot_load) begin
         if (vfp_mode_t'(boot_s2_r) == VFP_RESET) begin
            vib_warn_select_r <= VFP_AUTO;
         end else begin
            vib_warn_select_r <= vfp_mode_t'(boot_s2_r);
         end
      end else if (wr_sel) begin
         vib_warn_select_r <= vfp_mode_t'(bus_req.wdata[1:0]);
      end else if (learn_done) begin
         vib_warn_select_r <= VFP_MANUAL;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         threshold_multiplier_r <= MULT_RST;
      end else if (wr_mult) begin
         threshold_multiplier_r <= bus_req.wdata[MULT_W-1:0];
      end
   end

   // Learned values win over a software write in the same cycle
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         vib_average_characteristic_r <= AVG_RST;
         vib_standard_deviation_r <= STD_RST;
      end else if (boot_load && vfp_mode_t'(boot_s2_r) == VFP_RESET) begin
         vib_average_characteristic_r <= AVG_RST;
         vib_standard_deviation_r <= STD_RST;
      end else if (learn_done) begin
         vib_average_characteristic_r <= stat_mean;
         vib_standard_deviation_r <= std_est;
      end else begin
         if (wr_avg) begin
            vib_average_characteristic_r <= bus_req.wdata[LVL_W-1:0];
         end
         if (wr_std) begin
            vib_standard_deviation_r <= bus_req.wdata[LVL_W-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Threshold
   // ------------------------------------------------------------
   always_comb begin
      if (threshold_multiplier_r == MULT_RST) begin
         mult_eff = MULT_ZERO_SUB;
      end else begin
         mult_eff = threshold_multiplier_r;
      end
   end

   // Operands widened first so the product keeps its upper bits
   assign product = PROD_W'(vib_standard_deviation_r)
                    * PROD_W'(mult_eff);

   // The warning judges against the current sum, so a freshly learned
   // or written setting is never compared with the previous threshold
   assign thresh_cur = THR_W'(vib_average_characteristic_r)
                       + THR_W'(product);

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         thresh_r <= '0;
      end else begin
         thresh_r <= thresh_cur;
      end
   end

   // ------------------------------------------------------------
   // Learning timers
   // ------------------------------------------------------------
   // Counts run only while learning, so leaving automatic mode
   // starts a fresh learning period on the next entry.
   assign learning = (vib_warn_select_r == VFP_AUTO) && boot_done_r;
   assign sec_tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tick_cnt_r <= 32'h0;
      end else if (!learning || sec_tick) begin
         tick_cnt_r <= 32'h0;
      end else begin
         tick_cnt_r <= tick_cnt_r + 32'h1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cont_sec_r <= 32'h0;
         cont_met_r <= 1'b0;
      end else if (!learning) begin
         cont_sec_r <= 32'h0;
         cont_met_r <= 1'b0;
      end else if (!vib_in.running) begin
         cont_sec_r <= 32'h0;
      end else if (sec_tick && cont_sec_r < 32'(CONT_SECONDS)) begin
         cont_sec_r <= cont_sec_r + 32'h1;
         if (cont_sec_r + 32'h1 == 32'(CONT_SECONDS)) begin
            cont_met_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cum_sec_r <= 32'h0;
      end else if (!learning) begin
         cum_sec_r <= 32'h0;
      end else if (sec_tick && vib_in.running && vib_in.pos_vel_mode
                   && cum_sec_r < 32'(CUM_SECONDS)) begin
         cum_sec_r <= cum_sec_r + 32'h1;
      end
   end

   assign learn_done = learning && cont_met_r && stat_seeded
                       && (cum_sec_r >= 32'(CUM_SECONDS));

   // Standard deviation taken as 1.25 times the mean absolute deviation
   assign std_est = stat_dev + (stat_dev >> 2);

   vfp_stats #(
      .W(LVL_W),
      .SHIFT(STATS_SHIFT)
   ) u_stats (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .clear(!learning),
      .sample_valid(vib_in.valid && vib_in.running),
      .sample(vib_in.level),
      .mean(stat_mean),
      .dev(stat_dev),
      .seeded(stat_seeded)
   );

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         learned_r <= 1'b0;
      end else if (learn_done) begin
         learned_r <= 1'b1;
      end else if (learning) begin
         learned_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Prediction warning
   // ------------------------------------------------------------
   always_comb begin
      warn_nxt = warn_r;
      if (vib_warn_select_r != VFP_MANUAL) begin
         warn_nxt = 1'b0;
      end else if (vib_in.valid && vib_in.running) begin
         if (THR_W'(vib_in.level) > thresh_cur) begin
            warn_nxt = 1'b1;
         end else if (THR_W'(vib_in.level) < thresh_cur) begin
            warn_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         warn_r <= 1'b0;
      end else begin
         warn_r <= warn_nxt;
      end
   end

   always_comb begin
      unique case (vib_warn_select_r)
         VFP_AUTO: pred_status = PST_PREPARE;
         VFP_MANUAL: pred_status = warn_r ? PST_WARNING : PST_EXECUTE;
         VFP_OFF, VFP_RESET: pred_status = PST_DISABLED;
      endcase
   end

   // ------------------------------------------------------------
   // Interrupts
   // ------------------------------------------------------------
   always_comb begin
      irq_events = '0;
      irq_events[IRQ_WARN_SET] = warn_nxt && !warn_r;
      irq_events[IRQ_WARN_CLR] = !warn_nxt && warn_r;
      irq_events[IRQ_LEARNED] = learn_done;
   end

   // A new event in the reading cycle survives the clear
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_stat_r <= '0;
      end else begin
         irq_stat_r <= (rd_irq ? '0 : irq_stat_r) | irq_events;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_mask_r <= IRQ_MASK_RST;
      end else if (wr_mask) begin
         irq_mask_r <= bus_req.wdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(((rd_irq ? '0 : irq_stat_r) | irq_events)
                    & irq_mask_r);
      end
   end

   // ------------------------------------------------------------
   // Register read
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_r <= '0;
      end else if (bus_req.rd) begin
         rdata_r <= '0;
         case (bus_req.addr)
            OFS_SELECT: rdata_r[1:0] <= vib_warn_select_r;
            OFS_MULT: rdata_r[MULT_W-1:0] <= threshold_multiplier_r;
            OFS_AVG: rdata_r[LVL_W-1:0] <= vib_average_characteristic_r;
            OFS_STD: rdata_r[LVL_W-1:0] <= vib_standard_deviation_r;
            OFS_THRESH: rdata_r[THR_W-1:0] <= thresh_r;
            OFS_STATE: begin
               rdata_r[ST_PRED_LSB +: ST_PRED_W] <= pred_status;
               rdata_r[ST_WARN_BIT] <= warn_r;
               rdata_r[ST_LEARNED_BIT] <= learned_r;
               rdata_r[ST_CONT_MET_BIT] <= cont_met_r;
            end
            OFS_CONT_SEC: rdata_r <= cont_sec_r;
            OFS_CUM_SEC: rdata_r <= cum_sec_r;
            OFS_IRQ_STAT: rdata_r[IRQ_W-1:0] <= irq_stat_r;
            OFS_IRQ_MASK: rdata_r[IRQ_W-1:0] <= irq_mask_r;
            default: rdata_r <= '0;
         endcase
      end else begin
         rdata_r <= '0;
      end
   end
endmodule // vfp_top

// File: vfp_top_properties.sv
`timescale 1ns/100ps
module vfp_top_checker
   import vfp_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = 4,
   parameter int unsigned CUM_SECONDS = 5
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire vfp_pkg::vfp_bus_req_t bus_req,
   input wire logic [vfp_pkg::DATA_W-1:0] reg_rdata,
   input wire vfp_pkg::vfp_vib_t vib_in,
   input wire logic [1:0] boot_select,
   input wire logic vib_prediction_warning,
   input wire logic irq
);
   // One second is given up in case the tick was already part way round
   localparam int unsigned QUIET_CYC = (CUM_SECONDS - 1) * TICK_CYCLES;
   logic [1:0] sel_r;
   logic sel_known_r, avg_k_r, std_k_r;
   logic [LVL_W-1:0] avg_r, std_r;
   logic [MULT_W-1:0] mult_r, meff;
   logic [1:0] gap_r;
   logic [31:0] auto_cyc_r;
   logic [THR_W-1:0] thr;
   logic sel_off, auto_on, thr_ok, calm, smp;

   // --------------------------------------------------------------
   // Shadow of what software wrote
   // --------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sel_r <= 2'h0;
         sel_known_r <= 1'b0;
      end else if (bus_req.wr && bus_req.addr == OFS_SELECT) begin
         sel_r <= bus_req.wdata[1:0];
         sel_known_r <= 1'b1;
      end
   end

   // Learning may rewrite average and deviation, so those are only
   // trusted once written outside automatic mode
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mult_r <= MULT_RST;
         avg_r <= AVG_RST;
         std_r <= STD_RST;
         avg_k_r <= 1'b0;
         std_k_r <= 1'b0;
      end else begin
         if (bus_req.wr && bus_req.addr == OFS_MULT) begin
            mult_r <= bus_req.wdata[MULT_W-1:0];
         end
         if (bus_req.wr && bus_req.addr == OFS_AVG) begin
            avg_r <= bus_req.wdata[LVL_W-1:0];
         end
         if (bus_req.wr && bus_req.addr == OFS_STD) begin
            std_r <= bus_req.wdata[LVL_W-1:0];
         end
         if (!sel_known_r || sel_r == 2'h1) begin
            avg_k_r <= 1'b0;
            std_k_r <= 1'b0;
         end else begin
            if (bus_req.wr && bus_req.addr == OFS_AVG) begin
               avg_k_r <= 1'b1;
            end
            if (bus_req.wr && bus_req.addr == OFS_STD) begin
               std_k_r <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         gap_r <= 2'h0;
      end else if (bus_req.wr) begin
         gap_r <= 2'h0;
      end else if (gap_r != 2'h3) begin
         gap_r <= gap_r + 2'h1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         auto_cyc_r <= 32'h0;
      end else if (!auto_on) begin
         auto_cyc_r <= 32'h0;
      end else if (auto_cyc_r != 32'hffffffff) begin
         auto_cyc_r <= auto_cyc_r + 32'h1;
      end
   end

   assign meff = (mult_r == 4'h0) ? MULT_ZERO_SUB : mult_r;
   assign thr = THR_W'(avg_r) + THR_W'(std_r) * THR_W'(meff);
   assign sel_off = sel_known_r && (sel_r == 2'h0 || sel_r == 2'h3);
   assign auto_on = sel_known_r && sel_r == 2'h1;
   assign thr_ok = sel_known_r && sel_r == 2'h2 && avg_k_r && std_k_r;
   assign calm = gap_r >= 2'h1 && !bus_req.wr;
   assign smp = vib_in.valid && vib_in.running;

   // --------------------------------------------------------------
   // Properties
   // --------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   AST_WARN_RAISE: assert property (
      thr_ok && calm && smp && vib_in.level > thr |=> vib_prediction_warning)
      else $error("warning not raised above threshold");
   AST_WARN_CANCEL: assert property (
      thr_ok && calm && smp && vib_in.level < thr |=> !vib_prediction_warning)
      else $error("warning not cancelled below threshold");
   AST_WARN_EQUAL: assert property (
      thr_ok && calm && smp && vib_in.level == thr
      |=> $stable(vib_prediction_warning))
      else $error("warning moved on a level equal to threshold");
   AST_WARN_IDLE: assert property (
      thr_ok && calm && !smp |=> $stable(vib_prediction_warning))
      else $error("warning moved without a running sample");
   AST_WARN_OFF: assert property (
      sel_off [*3] |-> !vib_prediction_warning)
      else $error("warning active while disabled or reset");
   AST_AUTO_SILENT: assert property (
      (auto_on && auto_cyc_r < QUIET_CYC) [*3] |-> !vib_prediction_warning)
      else $error("warning active before learning could finish");
   AST_NO_EARLY_LEARN: assert property (
      bus_req.rd && bus_req.addr == OFS_SELECT && auto_on
      && auto_cyc_r + 1 < QUIET_CYC |=> reg_rdata == 32'h1)
      else $error("selection left automatic too early");
   AST_THRESH_READ: assert property (
      bus_req.rd && bus_req.addr == OFS_THRESH && avg_k_r && std_k_r
      && gap_r >= 2'h1 |=> reg_rdata == DATA_W'(thr))
      else $error("threshold readback differs from formula");
   AST_SELECT_READ: assert property (
      bus_req.rd && bus_req.addr == OFS_SELECT && sel_known_r
      && sel_r != 2'h1 |=> reg_rdata == DATA_W'(sel_r))
      else $error("selection readback differs from written value");
endmodule // vfp_top_checker

bind vfp_top vfp_top_checker #(
   .TICK_CYCLES(TICK_CYCLES),
   .CUM_SECONDS(CUM_SECONDS)
) u_vfp_top_checker (
   .core_clk(core_clk),
   .rst_b(rst_b),
   .bus_req(bus_req),
   .reg_rdata(reg_rdata),
   .vib_in(vib_in),
   .boot_select(boot_select),
   .vib_prediction_warning(vib_prediction_warning),
   .irq(irq)
);

// File: test_vfp_top.sv
`timescale 1ns/100ps
module test_vfp_top;
   import vfp_pkg::*;
   typedef struct {
      logic [DATA_W-1:0] exp;
      logic [DATA_W-1:0] msk;
      logic [ADDR_W-1:0] addr;
   } vfp_note_t;
   logic core_clk, rst_b, vib_prediction_warning, irq, rd_pend;
   vfp_bus_req_t bus_req;
   vfp_vib_t vib_in;
   logic [1:0] boot_select;
   logic [DATA_W-1:0] reg_rdata, av, sd, seed;
   logic [DATA_W-1:0] mults [4] = '{32'h0, 32'h1, 32'h9, 32'hf};
   vfp_note_t notes [$];
   vfp_note_t n;
   int fail_count, samples_checked, cycles, k;

   vfp_top #(.TICK_CYCLES(4), .CONT_SECONDS(3), .CUM_SECONDS(5)) u_vfp_top (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .bus_req(bus_req),
      .reg_rdata(reg_rdata),
      .vib_in(vib_in),
      .boot_select(boot_select),
      .vib_prediction_warning(vib_prediction_warning),
      .irq(irq)
   );

   // --------
   // Helpers
   // --------
   function automatic logic [31:0] xrand();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic compare(input string what, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus_req.addr <= a;
      bus_req.wdata <= d;
      bus_req.wr <= 1'b1;
      @(posedge core_clk);
      bus_req.wr <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [7:0] a, logic [31:0] e, m = '1);
      notes.push_back('{e & m, m, a});
      bus_req.addr <= a;
      bus_req.rd <= 1'b1;
      @(posedge core_clk);
      bus_req.rd <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic samp(input logic [15:0] lv, input logic run);
      vib_in.level <= lv;
      vib_in.running <= run;
      vib_in.valid <= 1'b1;
      @(posedge core_clk);
      vib_in.valid <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic chk_irq(input logic e, w);
      #1;
      compare("irq", {31'h0, e}, {31'h0, irq});
      compare("warn", {31'h0, w}, {31'h0, vib_prediction_warning});
      @(posedge core_clk);
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // Read data stand one cycle after the strobe, so notes pair in order
   always @(posedge core_clk) begin
      rd_pend <= bus_req.rd;
      if (rd_pend === 1'b1 && notes.size() > 0) begin
         n = notes.pop_front();
         compare($sformatf("reg %h", n.addr), n.exp, reg_rdata & n.msk);
      end
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         end_of_test();
      end
   end

   // --------
   // Scenarios
   // --------
   initial begin
      rst_b = 1'b0;
      bus_req = '0;
      vib_in = '0;
      vib_in.pos_vel_mode = 1'b1;
      boot_select = 2'h0;
      seed = 32'h8e39;
      repeat (16) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (6) @(posedge core_clk);
      rd(OFS_SELECT, 32'h0);
      rd(OFS_MULT, 32'h0);
      wr(8'h30, xrand());
      rd(8'h30, 32'h0);
      $display("test reset values done");
      wr(OFS_SELECT, 32'h2);
      wr(OFS_THRESH, xrand());
      foreach (mults[i]) begin
         av = xrand() & 32'hffff;
         sd = xrand() & 32'hffff;
         wr(OFS_AVG, av);
         wr(OFS_STD, sd);
         wr(OFS_MULT, mults[i]);
         rd(OFS_THRESH, av + sd * (mults[i] == 0 ? 32'd5 : mults[i]));
      end
      $display("test threshold formula done");
      wr(OFS_AVG, 32'd100);
      wr(OFS_STD, 32'd10);
      wr(OFS_MULT, 32'h0);
      wr(OFS_IRQ_MASK, 32'h1);
      samp(16'd151, 1'b1);
      chk_irq(1'b1, 1'b1);
      rd(OFS_STATE, 32'h13, 32'h1f);
      rd(OFS_IRQ_STAT, 32'h1, 32'h7);
      chk_irq(1'b0, 1'b1);
      samp(16'd150, 1'b1);
      rd(OFS_STATE, 32'h13, 32'h1f);
      samp(16'd149, 1'b0);
      rd(OFS_STATE, 32'h13, 32'h1f);
      samp(16'd149, 1'b1);
      rd(OFS_STATE, 32'h02, 32'h1f);
      chk_irq(1'b0, 1'b0);
      rd(OFS_IRQ_STAT, 32'h2, 32'h7);
      $display("test manual warning done");
      samp(16'd151, 1'b1);
      wr(OFS_SELECT, 32'h0);
      rd(OFS_STATE, 32'h00, 32'h1f);
      wr(OFS_SELECT, 32'h3);
      samp(16'd151, 1'b1);
      rd(OFS_STATE, 32'h00, 32'h10);
      rd(OFS_SELECT, 32'h3);
      rd(OFS_IRQ_STAT, 32'h3, 32'h7);
      $display("test disabled modes done");
      wr(OFS_IRQ_MASK, 32'h4);
      wr(OFS_SELECT, 32'h1);
      vib_in.level <= 16'd200;
      vib_in.running <= 1'b1;
      vib_in.valid <= 1'b1;
      rd(OFS_SELECT, 32'h1);
      rd(OFS_STATE, 32'h00, 32'h10);
      for (k = 0; k < 200 && irq !== 1'b1; k++) begin
         @(posedge core_clk);
      end
      vib_in.valid <= 1'b0;
      chk_irq(1'b1, 1'b0);
      rd(OFS_SELECT, 32'h2);
      rd(OFS_AVG, 32'd200);
      rd(OFS_STD, 32'd0);
      wr(OFS_MULT, 32'h6);
      rd(OFS_THRESH, 32'd200);
      rd(OFS_IRQ_STAT, 32'h4, 32'h7);
      chk_irq(1'b0, 1'b0);
      $display("test automatic learning done");
      wr(OFS_SELECT, 32'h3);
      boot_select <= 2'h3;
      rst_b <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (6) @(posedge core_clk);
      rd(OFS_SELECT, 32'h1);
      rd(OFS_AVG, 32'h0);
      rd(OFS_STD, 32'h0);
      repeat (2) @(posedge core_clk);
      $display("test threshold reset done");
      end_of_test();
   end
endmodule // test_vfp_top
